// ---- rtl/col_comparator_output_latch_mux.sv ----
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps

// How it works
// - Mirror bits 7,6 show comparator results
// - Mirror read disturbs no mismatch state
// - Mirror bits 5..2 read zero
// - Gate source bit resets 1, picks pin
// - Sync bit resets 0, else passthrough
// - Latch inputs active high, sampled on clk
// - Set is comparator 1 OR set pulse
// - Reset is comparator 2 OR reset pulse
// - Reset wins when both are high
// - Pulse bits clear themselves after one pulse
// - Route field picks four output pairings
// - Routing defaults to both comparators
// - Routing ignores comparator enable states
// - Latch register access types and resets
// - Sync samples on timer clock fall
module col_comparator_output_latch_mux
    import col_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic cmp1Result,
    input wire logic cmp2Result,
    input wire logic timerClk,
    input wire logic timerGatePin,
    output logic timerGate,
    output logic portOut1,
    output logic portOut2,
    output logic latchQ
);

    // Routing of comparators and latch to the two port outputs
    function automatic logic [1:0] routePair(
        input logic [1:0] sel,
        input logic c1,
        input logic c2,
        input logic q
    );
        logic [1:0] r;
        r = {c1, c2};
        case (sel)
            COL_ROUTE_CMP_CMP: r = {c1, c2};
            COL_ROUTE_C1_Q: r = {c1, q};
            COL_ROUTE_C2_Q: r = {c2, q};
            COL_ROUTE_Q_NQ: r = {q, ~q};
            default: r = {c1, c2};
        endcase
        return r;
    endfunction

    logic gateSrc_q;
    logic syncEn_q;
    logic [1:0] route_q;
    logic [1:0] spare_q;
    logic setPulse_q;
    logic rstPulse_q;
    logic latchQ_q;
    logic latchQ_d;
    logic tclkPrev_q;
    logic syncCap_q;
    logic timerGate_q;
    logic portOut1_q;
    logic portOut2_q;
    logic [7:0] regRdata_q;

    wire wrMirror = ce && regWr && (regAddr == ADDR_MIRROR);
    wire wrLatch = ce && regWr && (regAddr == ADDR_LATCH);
    wire rdAny = ce && regRd;

    // Read views; the mirror read has no side effect at all
    wire [7:0] mirrorView = {cmp1Result, cmp2Result, 4'h0,
                             gateSrc_q, syncEn_q};
    wire [7:0] latchView = {route_q, spare_q, setPulse_q,
                            rstPulse_q, 2'h0};
    wire [7:0] readMux = (regAddr == ADDR_MIRROR) ? mirrorView :
                         (regAddr == ADDR_LATCH) ? latchView : 8'h00;

    // Latch inputs, reset dominant; no comparator enable involved
    wire latchSet = cmp1Result | setPulse_q;
    wire latchRst = cmp2Result | rstPulse_q;
    assign latchQ_d = latchRst ? 1'b0 :
                      latchSet ? 1'b1 : latchQ_q;

    // Comparator 2 captured on the timer clock falling edge
    wire tclkFall = tclkPrev_q & ~timerClk;
    wire syncedCmp2Result = syncEn_q ? syncCap_q : cmp2Result;
    wire gateNext = gateSrc_q ? timerGatePin : syncedCmp2Result;

    wire [1:0] routed = routePair(route_q, cmp1Result, cmp2Result,
                                  latchQ_q);

    // Mirror and gate control register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gateSrc_q <= GATE_SRC_RST;
            syncEn_q <= SYNC_EN_RST;
        end else if (wrMirror) begin
            gateSrc_q <= regWdata[GATE_SRC_BIT];
            syncEn_q <= regWdata[SYNC_EN_BIT];
        end
    end

    // Latch and routing control register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            route_q <= ROUTE_RST;
            spare_q <= SPARE_RST;
        end else if (wrLatch) begin
            route_q <= regWdata[ROUTE_HI:ROUTE_LO];
            spare_q <= regWdata[SPARE_HI:SPARE_LO];
        end
    end

    // Self-clearing pulse bits; writing 0 has no effect
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            setPulse_q <= 1'b0;
            rstPulse_q <= 1'b0;
        end else if (ce) begin
            setPulse_q <= wrLatch && regWdata[PSET_BIT];
            rstPulse_q <= wrLatch && regWdata[PRST_BIT];
        end
    end

    // Latch state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latchQ_q <= 1'b0;
        end else if (ce) begin
            latchQ_q <= latchQ_d;
        end
    end

    // Timer clock edge tracking and comparator 2 capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tclkPrev_q <= 1'b0;
            syncCap_q <= 1'b0;
        end else if (ce) begin
            tclkPrev_q <= timerClk;
            if (tclkFall) begin
                syncCap_q <= cmp2Result;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timerGate_q <= GATE_SRC_RST;
            portOut1_q <= 1'b0;
            portOut2_q <= 1'b0;
        end else if (ce) begin
            timerGate_q <= gateNext;
            portOut1_q <= routed[1];
            portOut2_q <= routed[0];
        end
    end

    // Read data, valid the cycle after the read strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdata_q <= RDATA_RST;
        end else if (rdAny) begin
            regRdata_q <= readMux;
        end else if (ce) begin
            regRdata_q <= RDATA_RST;
        end
    end

    assign regRdata = regRdata_q;
    assign timerGate = timerGate_q;
    assign portOut1 = portOut1_q;
    assign portOut2 = portOut2_q;
    assign latchQ = latchQ_q;

    // Checks
    property p_mirror_bits;
        @(posedge clk) disable iff (rst)
        rdAny && regAddr == ADDR_MIRROR |=>
            regRdata_q[MIR_C1_BIT] == $past(cmp1Result) &&
            regRdata_q[MIR_C2_BIT] == $past(cmp2Result);
    endproperty
    a_mirror_bits: assert property (p_mirror_bits)
        else $error("mirror bits differ from comparator results");

    property p_mirror_zero;
        @(posedge clk) disable iff (rst)
        rdAny && regAddr == ADDR_MIRROR |=> regRdata_q[5:2] == 4'h0;
    endproperty
    a_mirror_zero: assert property (p_mirror_zero)
        else $error("unimplemented mirror bits not zero");

    property p_mirror_quiet;
        @(posedge clk) disable iff (rst)
        rdAny && !regWr |=> $stable(gateSrc_q) && $stable(route_q);
    endproperty
    a_mirror_quiet: assert property (p_mirror_quiet)
        else $error("read changed control state");

    property p_gate_pin;
        @(posedge clk) disable iff (rst)
        !rst && ce && gateSrc_q |=> timerGate_q == $past(timerGatePin);
    endproperty
    a_gate_pin: assert property (p_gate_pin)
        else $error("gate not taken from gate pin");

    property p_gate_async;
        @(posedge clk) disable iff (rst)
        ce && !gateSrc_q && !syncEn_q |=> timerGate_q == $past(cmp2Result);
    endproperty
    a_gate_async: assert property (p_gate_async)
        else $error("unsynced gate not comparator 2");

    property p_gate_sync;
        @(posedge clk) disable iff (rst)
        ce && !gateSrc_q && syncEn_q && $past(ce) && !wrMirror &&
            !tclkFall ##1 ce |=> timerGate_q == $past(syncCap_q, 2);
    endproperty
    a_gate_sync: assert property (p_gate_sync)
        else $error("synced gate changed off the falling edge");

    property p_latch_set;
        @(posedge clk) disable iff (rst)
        ce && latchSet && !latchRst |=> latchQ_q;
    endproperty
    a_latch_set: assert property (p_latch_set)
        else $error("latch did not set");

    property p_latch_rst;
        @(posedge clk) disable iff (rst)
        ce && (cmp2Result || rstPulse_q) |=> !latchQ_q;
    endproperty
    a_latch_rst: assert property (p_latch_rst)
        else $error("latch not reset dominant");

    property p_pulse_once;
        @(posedge clk) disable iff (rst)
        wrLatch && regWdata[PSET_BIT] ##1 ce && !wrLatch |=>
            setPulse_q == 1'b0 ##0 $past(setPulse_q);
    endproperty
    a_pulse_once: assert property (p_pulse_once)
        else $error("set pulse did not self clear");

    property p_route_qnq;
        @(posedge clk) disable iff (rst)
        ce && route_q == COL_ROUTE_Q_NQ |=>
            portOut1_q == $past(latchQ_q) && portOut2_q == !$past(latchQ_q);
    endproperty
    a_route_qnq: assert property (p_route_qnq)
        else $error("latch pair routing wrong");

    property p_latch_low;
        @(posedge clk) disable iff (rst)
        rdAny && regAddr == ADDR_LATCH |=> regRdata_q[1:0] == 2'h0;
    endproperty
    a_latch_low: assert property (p_latch_low)
        else $error("unimplemented latch bits not zero");

    property p_reset_defaults;
        @(posedge clk)
        $fell(rst) |-> route_q == ROUTE_RST && spare_q == SPARE_RST &&
            gateSrc_q == GATE_SRC_RST && syncEn_q == SYNC_EN_RST;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("control defaults wrong after reset");

    property p_rst_pulse_once;
        @(posedge clk) disable iff (rst)
        wrLatch && regWdata[PRST_BIT] ##1 ce && !wrLatch |=>
            rstPulse_q == 1'b0 ##0 $past(rstPulse_q);
    endproperty
    a_rst_pulse_once: assert property (p_rst_pulse_once)
        else $error("reset pulse did not self clear");

    property p_latch_hold;
        @(posedge clk) disable iff (rst)
        ce && !latchSet && !latchRst |=> $stable(latchQ_q);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latch changed with both inputs low");

    property p_route_c1q;
        @(posedge clk) disable iff (rst)
        ce && route_q == COL_ROUTE_C1_Q |=>
            portOut1_q == $past(cmp1Result) &&
            portOut2_q == $past(latchQ_q);
    endproperty
    a_route_c1q: assert property (p_route_c1q)
        else $error("comparator 1 and latch routing wrong");

    c_pulse_set: cover property (@(posedge clk) disable iff (rst)
        wrLatch && regWdata[PSET_BIT] ##2 latchQ_q);
    c_both_high: cover property (@(posedge clk) disable iff (rst)
        ce && latchSet && latchRst);
    c_sync_gate: cover property (@(posedge clk) disable iff (rst)
        ce && !gateSrc_q && syncEn_q && tclkFall);
    c_route_c2q: cover property (@(posedge clk) disable iff (rst)
        ce && route_q == COL_ROUTE_C2_Q);

endmodule

// ---- include/col_pkg.sv ----
package col_pkg;
    // Register addresses on the plain register port
    localparam logic [1:0] ADDR_MIRROR = 2'h0;
    localparam logic [1:0] ADDR_LATCH = 2'h1;

    // Mirror and gate control register fields
    localparam int MIR_C1_BIT = 7;
    localparam int MIR_C2_BIT = 6;
    localparam int GATE_SRC_BIT = 1;
    localparam int SYNC_EN_BIT = 0;

    // Latch and routing control register fields
    localparam int ROUTE_HI = 7;
    localparam int ROUTE_LO = 6;
    localparam int SPARE_HI = 5;
    localparam int SPARE_LO = 4;
    localparam int PSET_BIT = 3;
    localparam int PRST_BIT = 2;

    // Values after reset
    localparam logic GATE_SRC_RST = 1'h1;
    localparam logic SYNC_EN_RST = 1'h0;
    localparam logic [1:0] SPARE_RST = 2'h0;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // Output routing codes
    typedef enum logic [1:0] {
        COL_ROUTE_CMP_CMP = 2'h0,
        COL_ROUTE_C1_Q = 2'h1,
        COL_ROUTE_C2_Q = 2'h2,
        COL_ROUTE_Q_NQ = 2'h3
    } col_route_t;

    localparam col_route_t ROUTE_RST = COL_ROUTE_CMP_CMP;
endpackage

// ---- bench/col_far_model.sv ----
`timescale 1ns/1ps

// Comparators, gate pin and prescaled timer clock seen by the block
module col_far_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic c1Set,
    input wire logic c2Set,
    input wire logic pinSet,
    input wire logic tclkRun,
    output logic cmp1Result,
    output logic cmp2Result,
    output logic timerClk,
    output logic timerGatePin
);
    logic [1:0] divQ;

    assign cmp1Result = c1Set;
    assign cmp2Result = c2Set;
    assign timerGatePin = pinSet;

    // Timer clock after prescaler; holds its level while stopped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divQ <= 2'h0;
            timerClk <= 1'h1;
        end else if (tclkRun) begin
            divQ <= divQ + 2'h1;
            if (divQ == 2'h3) begin
                timerClk <= ~timerClk;
            end
        end
    end
endmodule

// ---- bench/tb_col_comparator_output_latch_mux.sv ----
`timescale 1ns/1ps

module tb_col_comparator_output_latch_mux;
    import col_pkg::*;
    logic clk, rst, ce, regWr, regRd, c1, c2, pin, run, rq, qv;
    logic [1:0] regAddr, rr;
    logic [7:0] regWdata, rdv, ex;
    logic [7:0] regRdata;
    logic cmp1Result, cmp2Result, timerClk, timerGatePin;
    logic timerGate, portOut1, portOut2, latchQ;
    int failCount = 0;
    int comparisons = 0;

    col_comparator_output_latch_mux u_col_comparator_output_latch_mux (
        .clk(clk), .rst(rst), .ce(ce), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .cmp1Result(cmp1Result),
        .cmp2Result(cmp2Result), .timerClk(timerClk),
        .timerGatePin(timerGatePin), .timerGate(timerGate),
        .portOut1(portOut1), .portOut2(portOut2), .latchQ(latchQ));

    col_far_model u_col_far_model (
        .clk(clk), .rst(rst), .c1Set(c1), .c2Set(c2), .pinSet(pin),
        .tclkRun(run), .cmp1Result(cmp1Result), .cmp2Result(cmp2Result),
        .timerClk(timerClk), .timerGatePin(timerGatePin));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            failCount++;
        end
        // Leave on a rising edge so following stimulus is edge aligned
        @(posedge clk);
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rchk(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        chk("regRdata", e, regRdata);
    endtask

    // Waits, then compares {timerGate, portOut1, portOut2, latchQ}
    task automatic ochk(input int n, input logic [7:0] e);
        repeat (n) @(posedge clk);
        @(negedge clk);
        chk("outputs", e, {4'h0, timerGate, portOut1, portOut2, latchQ});
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        failCount++;
        conclude();
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        c1 = 1'b0;
        c2 = 1'b0;
        pin = 1'b0;
        run = 1'b0;
        regAddr = 2'h0;
        regWdata = 8'h00;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rchk(ADDR_MIRROR, 8'h02);
        rchk(ADDR_LATCH, 8'h00);
        ochk(1, 8'h00);
        $display("test reset done");
        c1 <= 1'b1;
        ochk(3, 8'h05);
        rchk(ADDR_MIRROR, 8'h82);
        rchk(ADDR_MIRROR, 8'h82);
        c1 <= 1'b0;
        c2 <= 1'b1;
        ochk(3, 8'h02);
        rchk(ADDR_MIRROR, 8'h42);
        wr(ADDR_MIRROR, 8'hFF);
        rchk(ADDR_MIRROR, 8'h43);
        rchk(2'h2, 8'h00);
        wr(ADDR_MIRROR, 8'h02);
        pin <= 1'b1;
        ochk(3, 8'h0A);
        wr(ADDR_MIRROR, 8'h00);
        c2 <= 1'b0;
        ochk(3, 8'h00);
        $display("test mirror and gate done");
        wr(ADDR_MIRROR, 8'h01);
        c2 <= 1'b1;
        run <= 1'b1;
        ochk(12, 8'h0A);
        run <= 1'b0;
        c2 <= 1'b0;
        ochk(6, 8'h08);
        run <= 1'b1;
        ochk(12, 8'h00);
        run <= 1'b0;
        pin <= 1'b0;
        wr(ADDR_MIRROR, 8'h02);
        $display("test sync done");
        wr(ADDR_LATCH, 8'h08);
        ochk(3, 8'h01);
        rchk(ADDR_LATCH, 8'h00);
        wr(ADDR_LATCH, 8'h04);
        ochk(3, 8'h00);
        wr(ADDR_LATCH, 8'h08);
        wr(ADDR_LATCH, 8'h0C);
        ochk(3, 8'h00);
        c1 <= 1'b1;
        c2 <= 1'b1;
        ochk(3, 8'h06);
        $display("test latch done");
        // Pin enables sit outside the block; routing seen at its edge
        for (int i = 0; i < 8; i++) begin
            rr = i[1:0];
            qv = ~i[2];
            c1 <= i[2] & i[0];
            c2 <= i[2];
            wr(ADDR_LATCH, {6'h00, 2'h0} | {4'h0, qv, 3'h0});
            wr(ADDR_LATCH, {rr, 6'h30});
            rchk(ADDR_LATCH, {rr, 6'h30});
            case (rr)
                2'h0: ex = {5'h00, c1, c2, qv};
                2'h1: ex = {5'h00, c1, qv, qv};
                2'h2: ex = {5'h00, c2, qv, qv};
                default: ex = {5'h00, qv, ~qv, qv};
            endcase
            ochk(3, ex);
        end
        $display("test routing done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        ochk(1, 8'h06);
        rchk(ADDR_LATCH, 8'h00);
        rchk(ADDR_MIRROR, 8'hC2);
        ce <= 1'b0;
        wr(ADDR_MIRROR, 8'h01);
        ce <= 1'b1;
        rchk(ADDR_MIRROR, 8'hC2);
        $display("test second reset done");
        conclude();
    end
endmodule
